// ---- pkg/rivp_consts.vh ----
// Purpose: Constants for reset and interrupt vector placement.
// Assumes: Program word addresses are 12 bits wide.
// Notes:   Vector offsets are relative to the active vector base.
`ifndef RIVP_CONSTS_VH
`define RIVP_CONSTS_VH
`define RIVP_ADDR_W        12
`define RIVP_NUM_SRC       25
`define RIVP_RESET_ADDR    12'h000
`define RIVP_BOOT_ADDR     12'hC00
`define RIVP_VEC_FIRST     12'h001
`define RIVP_VEC_LAST      12'h019
`define RIVP_FUSE_UNPROG   1'b1
`define RIVP_FUSE_PROG     1'b0
`define RIVP_NUM_RESET     5'h01
`define RIVP_SRC_EXT0      5'h00
`define RIVP_SRC_EXT1      5'h01
`define RIVP_SRC_PC0       5'h02
`define RIVP_SRC_PC1       5'h03
`define RIVP_SRC_PC2       5'h04
`define RIVP_SRC_WDOG      5'h05
`define RIVP_SRC_T2CA      5'h06
`define RIVP_SRC_T2CB      5'h07
`define RIVP_SRC_T2OV      5'h08
`define RIVP_SRC_T1CP      5'h09
`define RIVP_SRC_T1CA      5'h0A
`define RIVP_SRC_T1CB      5'h0B
`define RIVP_SRC_T1OV      5'h0C
`define RIVP_SRC_T0CA      5'h0D
`define RIVP_SRC_T0CB      5'h0E
`define RIVP_SRC_T0OV      5'h0F
`define RIVP_SRC_SPI       5'h10
`define RIVP_SRC_RXC       5'h11
`define RIVP_SRC_TXBE      5'h12
`define RIVP_SRC_TXC       5'h13
`define RIVP_SRC_ADC       5'h14
`define RIVP_SRC_EEPR      5'h15
`define RIVP_SRC_ACMP      5'h16
`define RIVP_SRC_TWOW      5'h17
`define RIVP_SRC_STORE     5'h18
`define RIVP_OFF_EXT0      12'h001
`define RIVP_OFF_EXT1      12'h002
`define RIVP_OFF_PC0       12'h003
`define RIVP_OFF_PC1       12'h004
`define RIVP_OFF_PC2       12'h005
`define RIVP_OFF_WDOG      12'h006
`define RIVP_OFF_T2CA      12'h007
`define RIVP_OFF_T2CB      12'h008
`define RIVP_OFF_T2OV      12'h009
`define RIVP_OFF_T1CP      12'h00A
`define RIVP_OFF_T1CA      12'h00B
`define RIVP_OFF_T1CB      12'h00C
`define RIVP_OFF_T1OV      12'h00D
`define RIVP_OFF_T0CA      12'h00E
`define RIVP_OFF_T0CB      12'h00F
`define RIVP_OFF_T0OV      12'h010
`define RIVP_OFF_SPI       12'h011
`define RIVP_OFF_RXC       12'h012
`define RIVP_OFF_TXBE      12'h013
`define RIVP_OFF_TXC       12'h014
`define RIVP_OFF_ADC       12'h015
`define RIVP_OFF_EEPR      12'h016
`define RIVP_OFF_ACMP      12'h017
`define RIVP_OFF_TWOW      12'h018
`define RIVP_OFF_STORE     12'h019
`define RIVP_NUM_EXT0      5'h02
`define RIVP_NUM_EXT1      5'h03
`define RIVP_NUM_PC0       5'h04
`define RIVP_NUM_PC1       5'h05
`define RIVP_NUM_PC2       5'h06
`define RIVP_NUM_WDOG      5'h07
`define RIVP_NUM_T2CA      5'h08
`define RIVP_NUM_T2CB      5'h09
`define RIVP_NUM_T2OV      5'h0A
`define RIVP_NUM_T1CP      5'h0B
`define RIVP_NUM_T1CA      5'h0C
`define RIVP_NUM_T1CB      5'h0D
`define RIVP_NUM_T1OV      5'h0E
`define RIVP_NUM_T0CA      5'h0F
`define RIVP_NUM_T0CB      5'h10
`define RIVP_NUM_T0OV      5'h11
`define RIVP_NUM_SPI       5'h12
`define RIVP_NUM_RXC       5'h13
`define RIVP_NUM_TXBE      5'h14
`define RIVP_NUM_TXC       5'h15
`define RIVP_NUM_ADC       5'h16
`define RIVP_NUM_EEPR      5'h17
`define RIVP_NUM_ACMP      5'h18
`define RIVP_NUM_TWOW      5'h19
`define RIVP_NUM_STORE     5'h1A
`endif

// ---- core/rivp_prio_enc.v ----
// Purpose: Picks the pending request with the lowest vector number.
// Assumes: Bit 0 of the request word is vector number 2.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`include "rivp_consts.vh"
module rivp_prio_enc (
    input  wire [`RIVP_NUM_SRC-1:0] reqVec,
    output reg                      anyReq,
    output reg  [4:0]               reqIndex
);
    integer i;
    always @* begin
        anyReq   = 1'b0;
        reqIndex = 5'h00;
        // Scan from the top so that the lowest index is the last to win.
        for (i = `RIVP_NUM_SRC - 1; i >= 0; i = i - 1) begin
            if (reqVec[i]) begin
                anyReq   = 1'b1;
                reqIndex = i[4:0];
            end
        end
    end
endmodule // rivp_prio_enc

// ---- core/rivp_vector_gen.v ----
// Purpose: Reset and interrupt vector address generation for the core.
// Assumes: Requests are already enabled and qualified; inputs synchronous to sys_clk.
// Notes:   The core fetches from vectorAddr when vectorValid is high.
// Notes on behaviour
// - All reset causes share vector one at word 0x000 without boot reset.
// - External requests at 0x001, 0x002; pin-change requests at 0x003 to 0x005.
// - Watchdog time-out uses offset 0x006.
// - Second 8-bit timer: compare A 0x007, compare B 0x008, overflow 0x009.
// - 16-bit timer: capture 0x00A, compare A 0x00B, B 0x00C, overflow 0x00D.
// - First 8-bit timer: compare A 0x00E, compare B 0x00F, overflow 0x010.
// - Serial transfer 0x011; receive 0x012, buffer empty 0x013, transmit 0x014.
// - ADC 0x015, EEPROM 0x016, comparator 0x017, two-wire 0x018, store 0x019.
// - Programmed boot fuse starts execution at the boot reset address.
// - Vector select set adds the boot section start to each vector address.
// - Fuse value one means unprogrammed, zero means programmed.
// - Reset follows the fuse, vector base follows the select bit, independently.
// - Vector words are ordinary code; no special handling beyond address output.
// - Boot reset address is 0xC00; relocated vectors span 0xC01 to 0xC19.
`timescale 1ns/1ps
`include "rivp_consts.vh"
module rivp_vector_gen (
    input  wire                     sys_clk,
    input  wire                     rst_n,
    input  wire                     boot_reset_select_fuse,
    input  wire                     vector_select_to_boot,
    input  wire                     ext_irq_zero,
    input  wire                     ext_irq_one,
    input  wire                     pin_change_req_zero,
    input  wire                     pin_change_req_one,
    input  wire                     pin_change_req_two,
    input  wire                     watchdog_timeout_req,
    input  wire                     timer2CmpAReq,
    input  wire                     timer2CmpBReq,
    input  wire                     timer2OvfReq,
    input  wire                     timer1CaptReq,
    input  wire                     timer1CmpAReq,
    input  wire                     timer1CmpBReq,
    input  wire                     timer1OvfReq,
    input  wire                     timer0CmpAReq,
    input  wire                     timer0CmpBReq,
    input  wire                     timer0OvfReq,
    input  wire                     spiDoneReq,
    input  wire                     rxCompleteReq,
    input  wire                     tx_buffer_empty_req,
    input  wire                     txCompleteReq,
    input  wire                     adcDoneReq,
    input  wire                     eeprom_ready_req,
    input  wire                     analogCompReq,
    input  wire                     two_wire_serial_req,
    input  wire                     store_prog_mem_ready_req,
    output reg  [`RIVP_ADDR_W-1:0]  resetAddr_r,
    output reg  [`RIVP_ADDR_W-1:0]  vectorBase_r,
    output reg  [`RIVP_ADDR_W-1:0]  vectorAddr_r,
    output reg                      vectorValid_r,
    output reg  [4:0]               vectorNum_r
);
    reg                     rstSync1_r;
    reg                     rstSync2_r;
    reg                     fuseLatched_r;
    reg                     fuseTaken_r;
    wire [`RIVP_NUM_SRC-1:0] reqVec;
    wire                    anyReq;
    wire [4:0]              reqIndex;
    reg  [`RIVP_ADDR_W-1:0] resetAddr_nxt;
    reg  [`RIVP_ADDR_W-1:0] vectorBase_nxt;
    reg  [`RIVP_ADDR_W-1:0] vectorAddr_nxt;
    wire                    rstInt_n;

    // Word offset of each source from the active base. A table rather than an adder
    // keeps every vector word visible, at the cost of a wider decode.
    function [`RIVP_ADDR_W-1:0] srcOffset;
        input [4:0] idx;
        begin
            case (idx)
                `RIVP_SRC_EXT0:  srcOffset = `RIVP_OFF_EXT0;
                `RIVP_SRC_EXT1:  srcOffset = `RIVP_OFF_EXT1;
                `RIVP_SRC_PC0:   srcOffset = `RIVP_OFF_PC0;
                `RIVP_SRC_PC1:   srcOffset = `RIVP_OFF_PC1;
                `RIVP_SRC_PC2:   srcOffset = `RIVP_OFF_PC2;
                `RIVP_SRC_WDOG:  srcOffset = `RIVP_OFF_WDOG;
                `RIVP_SRC_T2CA:  srcOffset = `RIVP_OFF_T2CA;
                `RIVP_SRC_T2CB:  srcOffset = `RIVP_OFF_T2CB;
                `RIVP_SRC_T2OV:  srcOffset = `RIVP_OFF_T2OV;
                `RIVP_SRC_T1CP:  srcOffset = `RIVP_OFF_T1CP;
                `RIVP_SRC_T1CA:  srcOffset = `RIVP_OFF_T1CA;
                `RIVP_SRC_T1CB:  srcOffset = `RIVP_OFF_T1CB;
                `RIVP_SRC_T1OV:  srcOffset = `RIVP_OFF_T1OV;
                `RIVP_SRC_T0CA:  srcOffset = `RIVP_OFF_T0CA;
                `RIVP_SRC_T0CB:  srcOffset = `RIVP_OFF_T0CB;
                `RIVP_SRC_T0OV:  srcOffset = `RIVP_OFF_T0OV;
                `RIVP_SRC_SPI:   srcOffset = `RIVP_OFF_SPI;
                `RIVP_SRC_RXC:   srcOffset = `RIVP_OFF_RXC;
                `RIVP_SRC_TXBE:  srcOffset = `RIVP_OFF_TXBE;
                `RIVP_SRC_TXC:   srcOffset = `RIVP_OFF_TXC;
                `RIVP_SRC_ADC:   srcOffset = `RIVP_OFF_ADC;
                `RIVP_SRC_EEPR:  srcOffset = `RIVP_OFF_EEPR;
                `RIVP_SRC_ACMP:  srcOffset = `RIVP_OFF_ACMP;
                `RIVP_SRC_TWOW:  srcOffset = `RIVP_OFF_TWOW;
                `RIVP_SRC_STORE: srcOffset = `RIVP_OFF_STORE;
                default:         srcOffset = `RIVP_VEC_FIRST;
            endcase
        end
    endfunction

    // Vector number shown to the core; number one is kept for the reset vector.
    function [4:0] srcVecNum;
        input [4:0] idx;
        begin
            case (idx)
                `RIVP_SRC_EXT0:  srcVecNum = `RIVP_NUM_EXT0;
                `RIVP_SRC_EXT1:  srcVecNum = `RIVP_NUM_EXT1;
                `RIVP_SRC_PC0:   srcVecNum = `RIVP_NUM_PC0;
                `RIVP_SRC_PC1:   srcVecNum = `RIVP_NUM_PC1;
                `RIVP_SRC_PC2:   srcVecNum = `RIVP_NUM_PC2;
                `RIVP_SRC_WDOG:  srcVecNum = `RIVP_NUM_WDOG;
                `RIVP_SRC_T2CA:  srcVecNum = `RIVP_NUM_T2CA;
                `RIVP_SRC_T2CB:  srcVecNum = `RIVP_NUM_T2CB;
                `RIVP_SRC_T2OV:  srcVecNum = `RIVP_NUM_T2OV;
                `RIVP_SRC_T1CP:  srcVecNum = `RIVP_NUM_T1CP;
                `RIVP_SRC_T1CA:  srcVecNum = `RIVP_NUM_T1CA;
                `RIVP_SRC_T1CB:  srcVecNum = `RIVP_NUM_T1CB;
                `RIVP_SRC_T1OV:  srcVecNum = `RIVP_NUM_T1OV;
                `RIVP_SRC_T0CA:  srcVecNum = `RIVP_NUM_T0CA;
                `RIVP_SRC_T0CB:  srcVecNum = `RIVP_NUM_T0CB;
                `RIVP_SRC_T0OV:  srcVecNum = `RIVP_NUM_T0OV;
                `RIVP_SRC_SPI:   srcVecNum = `RIVP_NUM_SPI;
                `RIVP_SRC_RXC:   srcVecNum = `RIVP_NUM_RXC;
                `RIVP_SRC_TXBE:  srcVecNum = `RIVP_NUM_TXBE;
                `RIVP_SRC_TXC:   srcVecNum = `RIVP_NUM_TXC;
                `RIVP_SRC_ADC:   srcVecNum = `RIVP_NUM_ADC;
                `RIVP_SRC_EEPR:  srcVecNum = `RIVP_NUM_EEPR;
                `RIVP_SRC_ACMP:  srcVecNum = `RIVP_NUM_ACMP;
                `RIVP_SRC_TWOW:  srcVecNum = `RIVP_NUM_TWOW;
                `RIVP_SRC_STORE: srcVecNum = `RIVP_NUM_STORE;
                default:         srcVecNum = `RIVP_NUM_RESET;
            endcase
        end
    endfunction

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    assign rstInt_n = rstSync2_r;

    // Table order sets the index, so index order is vector-number order.
    assign reqVec[`RIVP_SRC_EXT0]  = ext_irq_zero;
    assign reqVec[`RIVP_SRC_EXT1]  = ext_irq_one;
    assign reqVec[`RIVP_SRC_PC0]   = pin_change_req_zero;
    assign reqVec[`RIVP_SRC_PC1]   = pin_change_req_one;
    assign reqVec[`RIVP_SRC_PC2]   = pin_change_req_two;
    assign reqVec[`RIVP_SRC_WDOG]  = watchdog_timeout_req;
    assign reqVec[`RIVP_SRC_T2CA]  = timer2CmpAReq;
    assign reqVec[`RIVP_SRC_T2CB]  = timer2CmpBReq;
    assign reqVec[`RIVP_SRC_T2OV]  = timer2OvfReq;
    assign reqVec[`RIVP_SRC_T1CP]  = timer1CaptReq;
    assign reqVec[`RIVP_SRC_T1CA]  = timer1CmpAReq;
    assign reqVec[`RIVP_SRC_T1CB]  = timer1CmpBReq;
    assign reqVec[`RIVP_SRC_T1OV]  = timer1OvfReq;
    assign reqVec[`RIVP_SRC_T0CA]  = timer0CmpAReq;
    assign reqVec[`RIVP_SRC_T0CB]  = timer0CmpBReq;
    assign reqVec[`RIVP_SRC_T0OV]  = timer0OvfReq;
    assign reqVec[`RIVP_SRC_SPI]   = spiDoneReq;
    assign reqVec[`RIVP_SRC_RXC]   = rxCompleteReq;
    assign reqVec[`RIVP_SRC_TXBE]  = tx_buffer_empty_req;
    assign reqVec[`RIVP_SRC_TXC]   = txCompleteReq;
    assign reqVec[`RIVP_SRC_ADC]   = adcDoneReq;
    assign reqVec[`RIVP_SRC_EEPR]  = eeprom_ready_req;
    assign reqVec[`RIVP_SRC_ACMP]  = analogCompReq;
    assign reqVec[`RIVP_SRC_TWOW]  = two_wire_serial_req;
    assign reqVec[`RIVP_SRC_STORE] = store_prog_mem_ready_req;

    rivp_prio_enc u_prio (
        .reqVec   (reqVec),
        .anyReq   (anyReq),
        .reqIndex (reqIndex)
    );

    // The fuse is a strap: it is caught once after reset release, never
    // through the asynchronous reset, so a later change waits for a reset.
    always @(posedge sys_clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            fuseLatched_r <= `RIVP_FUSE_UNPROG;
            fuseTaken_r   <= 1'b0;
        end else if (!fuseTaken_r) begin
            fuseLatched_r <= boot_reset_select_fuse;
            fuseTaken_r   <= 1'b1;
        end
    end

    always @* begin
        // Use the live fuse in the capture cycle so the first reset address is right.
        if ((fuseTaken_r ? fuseLatched_r : boot_reset_select_fuse) == `RIVP_FUSE_PROG) begin
            resetAddr_nxt = `RIVP_BOOT_ADDR;
        end else begin
            resetAddr_nxt = `RIVP_RESET_ADDR;
        end
        // The select bit moves only the interrupt table, never the reset word.
        if (vector_select_to_boot) begin
            vectorBase_nxt = `RIVP_BOOT_ADDR;
        end else begin
            vectorBase_nxt = `RIVP_RESET_ADDR;
        end
        vectorAddr_nxt = vectorBase_nxt + srcOffset(reqIndex);
    end

    // Only addresses leave this block; the words themselves stay ordinary
    // program memory, so nothing here blocks fetches at vector locations.
    always @(posedge sys_clk or negedge rstInt_n) begin
        if (!rstInt_n) begin
            resetAddr_r   <= `RIVP_RESET_ADDR;
            vectorBase_r  <= `RIVP_RESET_ADDR;
            vectorAddr_r  <= `RIVP_RESET_ADDR;
            vectorValid_r <= 1'b0;
            vectorNum_r   <= 5'h00;
        end else begin
            resetAddr_r   <= resetAddr_nxt;
            vectorBase_r  <= vectorBase_nxt;
            vectorValid_r <= anyReq;
            vectorAddr_r  <= anyReq ? vectorAddr_nxt : resetAddr_nxt;
            vectorNum_r   <= anyReq ? srcVecNum(reqIndex) : `RIVP_NUM_RESET;
        end
    end
endmodule // rivp_vector_gen

// ---- verification/rivp_vector_gen_assertions.sv ----
// Purpose: Assertions on the vector placement outputs.
// Assumes: Outputs follow inputs from the third edge after reset release.
// Notes:   Only the highest priority requests are watched directly.
`timescale 1ns/1ps
module rivp_vector_gen_assertions (
    input wire        sys_clk,
    input wire        rst_n,
    input wire        boot_reset_select_fuse,
    input wire        vector_select_to_boot,
    input wire        ext_irq_zero,
    input wire        ext_irq_one,
    input wire [11:0] resetAddr_r,
    input wire [11:0] vectorBase_r,
    input wire [11:0] vectorAddr_r,
    input wire        vectorValid_r,
    input wire [4:0]  vectorNum_r
);
    reg  [1:0]  upCnt_r;
    wire        live = upCnt_r == 2'h3;
    wire [11:0] base = vector_select_to_boot ? 12'hC00 : 12'h000;
    // The reset synchroniser delays the outputs, so checks wait for this counter.
    always @(posedge sys_clk or negedge rst_n)
        if (!rst_n) upCnt_r <= 2'h0;
        else if (!live) upCnt_r <= upCnt_r + 2'h1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_first_live; upCnt_r == 2'h2 ##1 live; endsequence
    a_fuse_capture: assert property (s_first_live |-> resetAddr_r ==
        ($past(boot_reset_select_fuse) ? 12'h000 : 12'hC00)) else $error("reset address wrong");
    a_fuse_hold: assert property (live && $past(live) |-> $stable(resetAddr_r))
        else $error("reset address moved");
    a_base_select: assert property (live |-> vectorBase_r == $past(base))
        else $error("vector base wrong");
    a_ext0_first: assert property (live && $past(ext_irq_zero) |-> vectorNum_r == 5'h02
        && vectorAddr_r == $past(base) + 12'h001) else $error("ext zero vector wrong");
    a_ext1_next: assert property (live && $past(ext_irq_one && !ext_irq_zero) |->
        vectorNum_r == 5'h03 && vectorAddr_r == $past(base) + 12'h002) else $error("ext one wrong");
    a_valid_span: assert property (vectorValid_r |-> vectorNum_r >= 5'h02 && vectorNum_r <= 5'h1A
        && vectorAddr_r == vectorBase_r + {7'h00, vectorNum_r} - 12'h001) else $error("span wrong");
    a_idle_reset: assert property (live && !vectorValid_r |-> vectorNum_r == 5'h01
        && vectorAddr_r == resetAddr_r) else $error("idle vector wrong");
    a_held_reset: assert property (upCnt_r == 2'h1 |-> !vectorValid_r
        && resetAddr_r == 12'h000 && vectorNum_r == 5'h00) else $error("early valid");
endmodule // rivp_vector_gen_assertions
bind rivp_vector_gen rivp_vector_gen_assertions u_chk (.sys_clk, .rst_n, .boot_reset_select_fuse,
    .vector_select_to_boot, .ext_irq_zero, .ext_irq_one, .resetAddr_r, .vectorBase_r,
    .vectorAddr_r, .vectorValid_r, .vectorNum_r);

// ---- verification/rivp_core_model.sv ----
// Purpose: Processor core stand-in that fetches from the offered address.
// Assumes: One fetch per clock, no wait states.
// Notes:   Fetches the vector while one is valid, else the reset address.
`timescale 1ns/1ps
module rivp_core_model (
    input  wire        sys_clk,
    input  wire [11:0] resetAddr_r,
    input  wire [11:0] vectorAddr_r,
    input  wire        vectorValid_r,
    output reg  [11:0] fetchAddr_r
);
    always @(posedge sys_clk) fetchAddr_r <= vectorValid_r ? vectorAddr_r : resetAddr_r;
endmodule // rivp_core_model

// ---- verification/tb.sv ----
// Purpose: Self-checking bench for vector placement.
// Assumes: Inputs change on the falling edge, outputs read at the next falling edge.
// Notes:   Covers every source in both table places and both fuse values.
`timescale 1ns/1ps
module tb;
    reg         sysClk = 1'b0;
    reg         rstN;
    reg         fuse;
    reg         sel;
    reg  [24:0] req;
    wire [11:0] rstA, baseA, vecA, fetchA;
    wire        vld;
    wire [4:0]  num;
    integer     error_cnt = 0;
    integer     samples_checked = 0;
    rivp_vector_gen dut (.sys_clk(sysClk), .rst_n(rstN), .boot_reset_select_fuse(fuse),
        .vector_select_to_boot(sel), .ext_irq_zero(req[0]), .ext_irq_one(req[1]),
        .pin_change_req_zero(req[2]), .pin_change_req_one(req[3]), .pin_change_req_two(req[4]),
        .watchdog_timeout_req(req[5]), .timer2CmpAReq(req[6]), .timer2CmpBReq(req[7]),
        .timer2OvfReq(req[8]), .timer1CaptReq(req[9]), .timer1CmpAReq(req[10]),
        .timer1CmpBReq(req[11]), .timer1OvfReq(req[12]), .timer0CmpAReq(req[13]),
        .timer0CmpBReq(req[14]), .timer0OvfReq(req[15]), .spiDoneReq(req[16]),
        .rxCompleteReq(req[17]), .tx_buffer_empty_req(req[18]), .txCompleteReq(req[19]),
        .adcDoneReq(req[20]), .eeprom_ready_req(req[21]), .analogCompReq(req[22]),
        .two_wire_serial_req(req[23]), .store_prog_mem_ready_req(req[24]), .resetAddr_r(rstA),
        .vectorBase_r(baseA), .vectorAddr_r(vecA), .vectorValid_r(vld), .vectorNum_r(num));
    rivp_core_model core (.sys_clk(sysClk), .resetAddr_r(rstA), .vectorAddr_r(vecA),
        .vectorValid_r(vld), .fetchAddr_r(fetchA));
    task chk(input string n, input logic [11:0] e, input logic [11:0] g);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task end_sim;
        if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task do_reset(input logic f);
        rstN = 1'b0;
        fuse = f;
        repeat (12) @(negedge sysClk);
        rstN = 1'b1;
        repeat (4) @(negedge sysClk);
    endtask
    task t_table;
        integer k;
        for (k = 0; k < 50; k = k + 1) begin
            req = 25'h0000001 << (k % 25);
            sel = k >= 25;
            @(negedge sysClk);
            chk("vector", (sel ? 12'hC00 : 12'h000) + 12'(k % 25 + 1), vecA);
            chk("number", 12'(k % 25 + 2), {7'h00, num});
            chk("base", sel ? 12'hC00 : 12'h000, baseA);
            chk("pending", 12'h001, {11'h000, vld});
        end
    endtask
    task t_prio;
        req = 25'h1FFFFFF;
        sel = 1'b0;
        @(negedge sysClk);
        chk("all pending", 12'h001, vecA);
        req = 25'h1008000;
        sel = 1'b1;
        @(negedge sysClk);
        chk("pair", 12'hC10, vecA);
        @(negedge sysClk);
        chk("vector fetch", 12'hC10, fetchA);
    endtask
    task t_idle(input logic [11:0] ra);
        req = 25'h0;
        repeat (2) @(negedge sysClk);
        chk("reset addr", ra, rstA);
        chk("idle vector", ra, vecA);
        chk("valid", 12'h000, {11'h000, vld});
        chk("fetch", ra, fetchA);
    endtask
    initial forever #50 sysClk = ~sysClk;
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        end_sim;
    end
    initial begin
        req = 25'h0;
        sel = 1'b1;
        do_reset(1'b1);
        t_idle(12'h000);
        t_table;
        t_prio;
        do_reset(1'b0);
        t_idle(12'hC00);
        fuse = 1'b1;
        t_idle(12'hC00);
        t_table;
        end_sim;
    end
endmodule // tb
